// File: hw/ldc_consts.svh
// constants for the led string dimming control block
//
// Behaviour
// - dimming-style bit low gives analog DC only
// - dimming-style bit high gives mixed phase-shifted PWM
// - phase offset is 360 over enabled strings
// - code is high byte then low nibble
// - low code bits dropped per output rate
// - new intensity applied only at period start
// - 200ns minimum pulse, 97.66ns width step
// - mixed: DC above switch point, else pulsed
// - transition field picks 12.5/25/50/100 percent
// - on-time scales inversely with switch point
// - no register interface: switch point 25%
// - rate field selects 2.5 to 40 kHz
// - no register interface: fixed 2.5 kHz
// - resolution drops one bit per doubling
// - strap floating mixed, strap high direct
// - source field 11 selects direct PWM
// - direct PWM follows input, no phase shift
// - source 00 uses measured input duty
// - source 01 uses mapped register code
// - source 10 multiplies register by duty
// - linear mapping default, log gives 1023 states
`ifndef LDC_CONSTS_SVH
`define LDC_CONSTS_SVH

// ****************************************
// register map
// ****************************************
`define LDC_OFS_BRIGHT_LO 8'h07
`define LDC_OFS_BRIGHT_HI 8'h08
`define LDC_RST_BYTE 8'h00

// ****************************************
// timing
// ****************************************
`define LDC_CLK_PS 8000
`define LDC_STEP_PS 97660
`define LDC_MIN_PW_PS 200000
`define LDC_STEP_CYC (`LDC_STEP_PS / `LDC_CLK_PS)
`define LDC_MIN_PW_CYC ((`LDC_MIN_PW_PS + `LDC_CLK_PS - 1) / `LDC_CLK_PS)
`define LDC_MIN_PW_STEPS ((`LDC_MIN_PW_CYC + `LDC_STEP_CYC - 1) / `LDC_STEP_CYC)

// ****************************************
// codes and defaults
// ****************************************
`define LDC_FULL_CODE 12'hfff
`define LDC_RATE_MAX 3'h4
`define LDC_RATE_NOREG 3'h0
`define LDC_XP_NOREG 2'h1
`define LDC_FRAC_BITS 12

`endif

// File: hw/ldc_duty_if.sv
// carrier for the measured input duty code
`timescale 1ns/1ps
interface ldc_duty_if;
  logic [11:0] code; // duty code, full scale 12'hfff
  logic valid; // one-cycle pulse on a new code
  modport src (output code, output valid);
  modport snk (input code, input valid);
endinterface

// File: hw/ldc_duty_meas.sv
// measures the input pulse duty cycle as a 12-bit code
`timescale 1ns/1ps
`include "ldc_consts.svh"
module ldc_duty_meas (
  input wire logic clk, // system clock
  input wire logic rst, // sync reset, active high
  input wire logic ce, // clock enable
  input wire logic pwm_in, // dimming input pin
  input wire logic step_tick, // one pulse per sample step
  ldc_duty_if.src duty // measured duty out
);
  import ldc_pkg::*;

  // ****************************************
  // period and high-time counters
  // ****************************************
  logic pwm_q; // previous input level
  logic [16:0] hi_q; // high steps this period
  logic [16:0] per_q; // steps this period
  logic rise_w; // rising input edge
  assign rise_w = pwm_in && !pwm_q;

  // counters saturate so a stuck input cannot wrap into a false code
  always_ff @(posedge clk) begin
    if (rst) begin
      pwm_q <= 1'b0;
      hi_q <= 17'h0;
      per_q <= 17'h0;
    end else if (ce) begin
      pwm_q <= pwm_in;
      if (rise_w) begin
        hi_q <= 17'h0;
        per_q <= 17'h0;
      end else if (step_tick && !per_q[16]) begin
        per_q <= per_q + 17'h1;
        hi_q <= hi_q + {16'h0, pwm_in};
      end
    end
  end

  // ****************************************
  // restoring divider, one quotient bit per clock
  // ****************************************
  ldc_div_st_t st_q; // divider state
  logic [17:0] rem_q; // partial remainder
  logic [16:0] den_q; // divisor
  logic [11:0] quo_q; // quotient so far
  logic [3:0] it_q; // bits left
  logic [11:0] code_q; // last duty code
  logic valid_q; // new code pulse
  logic [17:0] shl_w; // remainder shifted
  logic fit_w; // subtract fits
  assign shl_w = {rem_q[16:0], 1'b0};
  assign fit_w = shl_w >= {1'b0, den_q};

  // a new edge while dividing is dropped; the next period retries
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= LDC_DV_IDLE;
      rem_q <= 18'h0;
      den_q <= 17'h0;
      quo_q <= 12'h0;
      it_q <= 4'h0;
      code_q <= 12'h0;
      valid_q <= 1'b0;
    end else if (ce) begin
      valid_q <= 1'b0;
      case (st_q)
        LDC_DV_IDLE: begin
          if (rise_w && per_q == 17'h0) begin // no period seen yet
            st_q <= LDC_DV_IDLE;
          end else if (rise_w && hi_q >= per_q) begin // full duty
            code_q <= `LDC_FULL_CODE;
            valid_q <= 1'b1;
          end else if (rise_w) begin
            rem_q <= {1'b0, hi_q};
            den_q <= per_q;
            quo_q <= 12'h0;
            it_q <= 4'(`LDC_FRAC_BITS);
            st_q <= LDC_DV_RUN;
          end
        end
        LDC_DV_RUN: begin
          rem_q <= fit_w ? shl_w - {1'b0, den_q} : shl_w;
          quo_q <= {quo_q[10:0], fit_w};
          it_q <= it_q - 4'h1;
          if (it_q == 4'h1) begin
            code_q <= {quo_q[10:0], fit_w};
            valid_q <= 1'b1;
            st_q <= LDC_DV_IDLE;
          end
        end
        default: st_q <= LDC_DV_IDLE;
      endcase
    end
  end

  assign duty.code = code_q;
  assign duty.valid = valid_q;

  // ****************************************
  // checks
  // ****************************************
  a_div_length: assert property (@(posedge clk) disable iff (rst)
    (ce && st_q == LDC_DV_IDLE && rise_w && per_q != 17'h0 && hi_q < per_q)
      |=> (st_q == LDC_DV_RUN && it_q == 4'(`LDC_FRAC_BITS)))
    else $error("divider did not start with full bit count");
endmodule

// File: hw/ldc_pkg.sv
// types shared by the led string dimming control block
package ldc_pkg;
  // brightness source field
  typedef enum logic [1:0] {
    LDC_SRC_PWM = 2'h0,
    LDC_SRC_REG = 2'h1,
    LDC_SRC_MUL = 2'h2,
    LDC_SRC_DIRECT = 2'h3
  } ldc_src_t;
  // mode strap level when no register interface
  typedef enum logic [1:0] {
    LDC_STRAP_GND = 2'h0,
    LDC_STRAP_FLOAT = 2'h1,
    LDC_STRAP_VDD = 2'h2
  } ldc_strap_t;
  // dimming scheme, one-hot
  typedef enum logic [2:0] {
    LDC_SCH_ANALOG = 3'b001,
    LDC_SCH_MIXED = 3'b010,
    LDC_SCH_DIRECT = 3'b100
  } ldc_scheme_t;
  // duty divider states, one-hot
  typedef enum logic [1:0] {
    LDC_DV_IDLE = 2'b01,
    LDC_DV_RUN = 2'b10
  } ldc_div_st_t;
endpackage

// File: hw/ldc_top.sv
// led string dimming control: brightness source, mapping and sink drive
`timescale 1ns/1ps
`include "ldc_consts.svh"
module ldc_top #(
  parameter int unsigned NSTR = 6 // current sink strings, at most 7
) (
  input wire logic CLK, // system clock, 125 MHz
  input wire logic RST, // sync reset, active high
  input wire logic CE, // clock enable, freezes all state when low
  input wire logic PWM_IN, // dimming input pin
  input wire logic REG_IF_EN, // register interface in use
  input wire ldc_pkg::ldc_strap_t MODE_STRAP, // mode strap level
  input wire logic [NSTR-1:0] LED_EN, // string enables
  input wire logic DIM_MODE, // dimming style, 1 = mixed
  input wire logic [1:0] XPOINT_SEL, // transition point select
  input wire logic [2:0] RATE_SEL, // led pwm rate select
  input wire ldc_pkg::ldc_src_t SRC_SEL, // brightness source select
  input wire logic LOG_MAP, // logarithmic mapping
  input wire logic REG_WE, // register write strobe
  input wire logic [7:0] REG_ADDR, // register address
  input wire logic [7:0] REG_WDATA, // register write data
  output logic [7:0] REG_RDATA, // register read data
  output logic [NSTR-1:0] SINK_ON, // per string sink on
  output logic [11:0] SINK_LEVEL, // sink current level
  output logic [11:0] BRIGHT_CODE // brightness in use
);
  import ldc_pkg::*;

  // ****************************************
  // helper functions
  // ****************************************
  // enabled strings below a given position
  function automatic logic [2:0] count_below(input logic [NSTR-1:0] en, input int idx);
    logic [2:0] c;
    c = 3'h0;
    for (int j = 0; j < NSTR; j++) begin
      if (j < idx) begin
        c = c + {2'h0, en[j]};
      end
    end
    return c;
  endfunction

  // period split evenly among the enabled strings
  function automatic logic [11:0] phase_step(input logic [12:0] per, input logic [2:0] n);
    logic [12:0] q;
    case (n)
      3'h2: q = per / 13'h2;
      3'h3: q = per / 13'h3;
      3'h4: q = per / 13'h4;
      3'h5: q = per / 13'h5;
      3'h6: q = per / 13'h6;
      3'h7: q = per / 13'h7;
      default: q = 13'h0; // one string needs no offset
    endcase
    return q[11:0];
  endfunction

  // piecewise exponential curve over the top ten code bits
  function automatic logic [11:0] log_curve(input logic [11:0] c);
    logic [9:0] x;
    logic [13:0] v;
    x = c[11:2];
    if (x[9:7] == 3'h0) begin
      v = {7'h0, x[6:0]};
    end else begin
      v = 14'({1'b1, x[6:0]}) << (x[9:7] - 3'h1);
    end
    return (x == 10'h0) ? 12'h0 : v[13:2];
  endfunction

  // linear by default, curve when asked
  function automatic logic [11:0] map_code(input logic [11:0] c, input logic lg);
    return lg ? log_curve(c) : c;
  endfunction

  // ****************************************
  // brightness registers
  // ****************************************
  logic [7:0] lo_q; // low nibble register
  logic [7:0] hi_q; // high byte register
  logic [11:0] code_q; // committed brightness code
  logic wr_lo_w; // low register write
  logic wr_hi_w; // high register write
  assign wr_lo_w = CE && REG_WE && REG_ADDR == `LDC_OFS_BRIGHT_LO;
  assign wr_hi_w = CE && REG_WE && REG_ADDR == `LDC_OFS_BRIGHT_HI;

  // the low nibble waits until the high byte arrives, so half a value never shows
  always_ff @(posedge CLK) begin
    if (RST) begin
      lo_q <= `LDC_RST_BYTE;
      hi_q <= `LDC_RST_BYTE;
      code_q <= 12'h0;
    end else begin
      if (wr_lo_w) begin
        lo_q <= REG_WDATA;
      end
      if (wr_hi_w) begin
        hi_q <= REG_WDATA;
        code_q <= {REG_WDATA, lo_q[7:4]};
      end
    end
  end

  // read mux, unmapped addresses read zero
  logic [7:0] rdata_w; // selected read data
  assign rdata_w = (REG_ADDR == `LDC_OFS_BRIGHT_LO) ? lo_q :
                   (REG_ADDR == `LDC_OFS_BRIGHT_HI) ? hi_q : 8'h00;

  // ****************************************
  // strap capture
  // ****************************************
  ldc_strap_t strap_q; // strap level seen after reset
  logic strap_taken_q; // strap captured

  // sampled once after release; later changes are ignored
  always_ff @(posedge CLK) begin
    if (RST) begin
      strap_q <= LDC_STRAP_GND;
      strap_taken_q <= 1'b0;
    end else if (CE && !strap_taken_q) begin
      strap_q <= MODE_STRAP;
      strap_taken_q <= 1'b1;
    end
  end

  // ****************************************
  // effective settings
  // ****************************************
  ldc_src_t src_w; // source in force
  logic mixed_w; // mixed style in force
  logic [1:0] xp_w; // transition point in force
  logic [2:0] rate_w; // output rate in force
  logic log_w; // log mapping in force
  ldc_scheme_t scheme_w; // scheme for next period
  assign src_w = REG_IF_EN ? SRC_SEL :
                 (strap_q == LDC_STRAP_VDD) ? LDC_SRC_DIRECT : LDC_SRC_PWM;
  assign mixed_w = REG_IF_EN ? DIM_MODE : (strap_q == LDC_STRAP_FLOAT);
  assign xp_w = REG_IF_EN ? XPOINT_SEL : `LDC_XP_NOREG;
  // codes above the fastest rate are held at the fastest
  assign rate_w = !REG_IF_EN ? `LDC_RATE_NOREG :
                  (RATE_SEL > `LDC_RATE_MAX) ? `LDC_RATE_MAX : RATE_SEL;
  assign log_w = REG_IF_EN && LOG_MAP;
  assign scheme_w = (src_w == LDC_SRC_DIRECT) ? LDC_SCH_DIRECT :
                    mixed_w ? LDC_SCH_MIXED : LDC_SCH_ANALOG;

  // ****************************************
  // step timebase and output period
  // ****************************************
  logic [3:0] div_q; // clocks within a step
  logic step_tick_w; // one step done
  logic [11:0] cnt_q; // step within period
  logic [2:0] rate_q; // rate of running period
  logic [11:0] mask_w; // last step of period
  logic frame_end_w; // last step of period done
  assign step_tick_w = CE && div_q == 4'(`LDC_STEP_CYC - 1);
  assign mask_w = `LDC_FULL_CODE >> rate_q;
  assign frame_end_w = step_tick_w && cnt_q == mask_w;

  // step counter and period position
  always_ff @(posedge CLK) begin
    if (RST) begin
      div_q <= 4'h0;
      cnt_q <= 12'h0;
    end else if (CE) begin
      div_q <= step_tick_w ? 4'h0 : div_q + 4'h1;
      if (step_tick_w) begin
        cnt_q <= frame_end_w ? 12'h0 : cnt_q + 12'h1;
      end
    end
  end

  // ****************************************
  // duty measurement
  // ****************************************
  ldc_duty_if duty_bus();
  ldc_duty_meas u_meas (
    .clk(CLK),
    .rst(RST),
    .ce(CE),
    .pwm_in(PWM_IN),
    .step_tick(step_tick_w),
    .duty(duty_bus.src)
  );

  // ****************************************
  // brightness selection and mixed dimming math
  // ****************************************
  logic [11:0] map_reg_w; // mapped register code
  logic [11:0] map_pwm_w; // mapped duty code
  logic [23:0] prod_w; // register times duty
  logic [11:0] src_code_w; // chosen brightness
  logic [11:0] bright_w; // truncated to the rate
  logic [1:0] shift_w; // log2 of full over switch point
  logic [12:0] sp_w; // switch point code
  logic [14:0] scaled_w; // brightness over switch point
  logic [11:0] raw_on_w; // on steps before clamp
  logic [11:0] on_w; // on steps in period
  logic dc_w; // at or above switch point
  logic [12:0] per_w; // steps in next period
  assign map_reg_w = map_code(code_q, log_w);
  assign map_pwm_w = map_code(duty_bus.code, log_w);
  assign prod_w = map_reg_w * duty_bus.code;
  assign src_code_w = (src_w == LDC_SRC_REG) ? map_reg_w :
                      (src_w == LDC_SRC_MUL) ? prod_w[23:12] : map_pwm_w;
  // dropping bits below the period length costs one bit per doubling
  assign bright_w = src_code_w & (`LDC_FULL_CODE << rate_w);
  assign shift_w = 2'h3 - xp_w;
  assign sp_w = 13'h1000 >> shift_w;
  assign dc_w = ({1'b0, bright_w} >= sp_w) || bright_w == `LDC_FULL_CODE;
  // peak is the switch point, so on-time grows by the same ratio
  assign scaled_w = {3'h0, bright_w} << shift_w;
  assign raw_on_w = 12'(scaled_w >> rate_w);
  assign on_w = (raw_on_w != 12'h0 && raw_on_w < 12'(`LDC_MIN_PW_STEPS)) ?
                12'(`LDC_MIN_PW_STEPS) : raw_on_w;
  assign per_w = {1'b0, `LDC_FULL_CODE >> rate_w} + 13'h1;

  // ****************************************
  // per period snapshot
  // ****************************************
  ldc_scheme_t scheme_q; // scheme of running period
  logic [11:0] bright_q; // brightness of running period
  logic [11:0] on_q; // on steps of running period
  logic [11:0] lvl_q; // pulse peak level
  logic dc_q; // dc output this period
  logic [NSTR-1:0] en_q; // enables at period start
  logic [11:0] step_q; // phase step between strings

  // intensity, rate and phase split all change only on a period boundary
  always_ff @(posedge CLK) begin
    if (RST) begin
      scheme_q <= LDC_SCH_ANALOG;
      rate_q <= `LDC_RATE_NOREG;
      bright_q <= 12'h0;
      on_q <= 12'h0;
      lvl_q <= 12'h0;
      dc_q <= 1'b1;
      en_q <= '0;
      step_q <= 12'h0;
    end else if (frame_end_w) begin
      scheme_q <= scheme_w;
      rate_q <= rate_w;
      bright_q <= bright_w;
      on_q <= on_w;
      lvl_q <= `LDC_FULL_CODE >> shift_w;
      dc_q <= dc_w;
      en_q <= LED_EN;
      step_q <= phase_step(per_w, count_below(LED_EN, NSTR));
    end
  end

  // ****************************************
  // phase shifted pulses
  // ****************************************
  logic [NSTR-1:0] phase_on_w; // pulse window per string
  for (genvar gi = 0; gi < NSTR; gi++) begin : g_str
    logic [11:0] ofs_w; // start offset of this string
    logic [11:0] rel_w; // position past the offset
    assign ofs_w = 12'(count_below(en_q, gi) * step_q);
    assign rel_w = (cnt_q - ofs_w) & mask_w;
    assign phase_on_w[gi] = en_q[gi] && rel_w < on_q;
  end

  // ****************************************
  // sink drive
  // ****************************************
  logic [NSTR-1:0] on_d; // next sink enables
  logic [11:0] level_d; // next sink level

  // scheme decides between dc level, pulses and direct follow
  always_comb begin
    on_d = '0;
    level_d = 12'h0;
    case (scheme_q)
      LDC_SCH_ANALOG: begin
        on_d = LED_EN;
        level_d = bright_q;
      end
      LDC_SCH_MIXED: begin
        if (dc_q) begin // above switch point
          on_d = LED_EN;
          level_d = bright_q;
        end else begin
          on_d = LED_EN & phase_on_w;
          level_d = lvl_q;
        end
      end
      LDC_SCH_DIRECT: begin
        on_d = LED_EN & {NSTR{PWM_IN}};
        level_d = `LDC_FULL_CODE;
      end
      default: begin
        on_d = '0;
        level_d = 12'h0;
      end
    endcase
  end

  // all outputs leave from flops
  always_ff @(posedge CLK) begin
    if (RST) begin
      SINK_ON <= '0;
      SINK_LEVEL <= 12'h0;
      BRIGHT_CODE <= 12'h0;
      REG_RDATA <= 8'h00;
    end else if (CE) begin
      SINK_ON <= on_d;
      SINK_LEVEL <= level_d;
      BRIGHT_CODE <= bright_q;
      REG_RDATA <= rdata_w;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);

  sequence s_lo_write;
    wr_lo_w && !wr_hi_w;
  endsequence
  sequence s_hi_write;
    wr_hi_w;
  endsequence

  a_code_pairing: assert property (
    s_lo_write ##1 s_hi_write |=> code_q[11:4] == $past(REG_WDATA) &&
      code_q[3:0] == 4'($past(REG_WDATA, 2) >> 4))
    else $error("brightness code not formed from high byte and low nibble");
  a_low_holds_code: assert property (s_lo_write |=> $stable(code_q))
    else $error("low nibble write changed the committed code");
  a_intensity_at_frame: assert property (!frame_end_w |=> $stable(bright_q))
    else $error("intensity changed inside a period");
  a_direct_follow: assert property (
    CE && scheme_q == LDC_SCH_DIRECT |=> SINK_ON == ($past(LED_EN) & {NSTR{$past(PWM_IN)}}))
    else $error("direct mode sinks do not follow the input");
  a_analog_dc: assert property (
    CE && scheme_q == LDC_SCH_ANALOG |=> SINK_LEVEL == $past(bright_q) && SINK_ON == $past(LED_EN))
    else $error("analog mode did not drive dc level");
  a_noreg_rate: assert property (!REG_IF_EN && frame_end_w |=> rate_q == 3'h0)
    else $error("fixed output rate not kept without register interface");
  a_min_pulse: assert property (on_q == 12'h0 || on_q >= 12'(`LDC_MIN_PW_STEPS))
    else $error("pulse shorter than the minimum width");
  a_mixed_peak: assert property (
    CE && scheme_q == LDC_SCH_MIXED && !dc_q |=> SINK_LEVEL == $past(lvl_q))
    else $error("pulsed level is not the switch point level");
  a_step_period: assert property (step_tick_w |=> !step_tick_w ##10 CE |-> div_q != 4'h0)
    else $error("step timebase too short");
endmodule

// File: test/ldc_host_model.sv
// host controller model: register writes and reads, dimming input pulses
`timescale 1ns/1ps
`include "ldc_consts.svh"
module ldc_host_model (
  input wire logic clk, // system clock
  input wire logic [7:0] rdata, // register read data
  output logic we, // write strobe
  output logic [7:0] addr, // register address
  output logic [7:0] wdata, // write data
  output logic pwm // dimming input level
);
  // ****
  // register access
  // ****
  // idle bus and a low input from time zero
  initial begin
    we = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    pwm = 1'b0;
  end
  // one write; an idle edge after it so the strobe is never set twice in a step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
    @(posedge clk);
  endtask
  // full code: low nibble first, then the high byte that commits it, strobe held between
  task automatic wr_code(input logic [11:0] c);
    addr <= `LDC_OFS_BRIGHT_LO;
    wdata <= {c[3:0], 4'h0};
    we <= 1'b1;
    @(posedge clk);
    addr <= `LDC_OFS_BRIGHT_HI;
    wdata <= c[11:4];
    @(posedge clk);
    we <= 1'b0;
    @(posedge clk);
  endtask
  // read data is registered, so look two edges after the address lands
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    addr <= a;
    repeat (2) @(posedge clk);
    @(negedge clk);
    d = rdata;
  endtask
  // ****
  // dimming input
  // ****
  // one 6400-clock period (under 20 kHz), pulse clamped to 25 clocks (200ns) or more
  task automatic pulse(input int hi);
    int h;
    h = (hi < 25) ? 25 : ((hi > 6375) ? 6375 : hi);
    pwm <= 1'b1;
    repeat (h) @(posedge clk);
    pwm <= 1'b0;
    repeat (6400 - h) @(posedge clk);
  endtask
endmodule

// File: test/ldc_top_tb.sv
// self-checking bench for the led string dimming control block
`timescale 1ns/1ps
`include "ldc_consts.svh"
module ldc_top_tb;
  import ldc_pkg::*;
  localparam int PER = 3072; // clocks per period at the 40 kHz rate
  logic clk, rst, pwm, we, dim_mode, reg_if;
  logic [7:0] addr, wdata, rdata, rd_v;
  logic [5:0] led_en, sink_on, exp_on;
  logic [1:0] xp;
  logic [2:0] rate;
  ldc_src_t src;
  logic [11:0] lvl, code, lvl_on;
  int mismatches, n_tests, on0, dummy;
  int rise [6];

  ldc_top #(.NSTR(6)) i_dut (.CLK(clk), .RST(rst), .CE(1'b1), .PWM_IN(pwm),
    .REG_IF_EN(reg_if), .MODE_STRAP(LDC_STRAP_FLOAT), .LED_EN(led_en), .DIM_MODE(dim_mode),
    .XPOINT_SEL(xp), .RATE_SEL(rate), .SRC_SEL(src), .LOG_MAP(1'b0), .REG_WE(we),
    .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata), .SINK_ON(sink_on),
    .SINK_LEVEL(lvl), .BRIGHT_CODE(code));
  ldc_host_model i_host (.clk(clk), .rdata(rdata), .we(we), .addr(addr), .wdata(wdata),
    .pwm(pwm));

  // ****
  // helpers
  // ****
  task automatic check_val(input logic [11:0] got, input logic [11:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_cnt(input int got, input int exp);
    n_tests++;
    if (got != exp) begin
      mismatches++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // peak level is the switch point fraction of full scale
  function automatic logic [11:0] exp_lvl(input logic [1:0] x);
    return 12'hfff >> (2'h3 - x);
  endfunction
  // code 0x100 is 16 of 256 steps, stretched by one over the switch point
  function automatic int exp_ontime(input logic [1:0] x);
    return 16 * (8 >> x) * 12;
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // one period window: on-time and level of string 0, rise of every string
  task automatic measure();
    logic [5:0] prev;
    on0 = 0;
    rise = '{default: -1};
    @(negedge clk);
    prev = sink_on;
    for (int c = 0; c < PER; c++) begin
      @(negedge clk);
      if (sink_on[0] === 1'b1) begin
        on0++;
        lvl_on = lvl;
      end
      for (int k = 0; k < 6; k++) begin
        if (sink_on[k] === 1'b1 && prev[k] === 1'b0) rise[k] = c;
      end
      prev = sink_on;
    end
    @(posedge clk);
  endtask
  // each enabled string starts rank times period over count after the first
  task automatic check_phase();
    int n, r, f;
    n = $countones(led_en);
    r = 0;
    f = -1;
    for (int k = 0; k < 6; k++) begin
      if (led_en[k]) begin
        if (f < 0) f = k;
        check_cnt((rise[k] - rise[f] + PER) % PER, r * (256 / n) * 12);
        r++;
      end
    end
  endtask
  task automatic finish_test();
    $display("mismatches %0d, comparisons %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ****
  // clock, watchdog and sequence
  // ****
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // the sequence needs about 102k clocks; a hang ends here
  initial begin
    #(108000 * 8);
    mismatches++;
    finish_test();
  end
  initial begin
    rst = 1'b1;
    reg_if = 1'b1;
    led_en = 6'h3f;
    dim_mode = 1'b0;
    xp = 2'h0;
    rate = 3'h2;
    src = LDC_SRC_REG;
    mismatches = 0;
    n_tests = 0;
    dummy = $urandom(32'h029f);
    cyc(5);
    rst <= 1'b0;
    @(posedge clk);
    // full code, then a lone low write that must not reach the code
    i_host.wr_code(12'h5cb);
    i_host.wr(`LDC_OFS_BRIGHT_LO, 8'h30);
    i_host.rd(`LDC_OFS_BRIGHT_LO, rd_v);
    check_val({4'h0, rd_v}, 12'h030);
    i_host.rd(`LDC_OFS_BRIGHT_HI, rd_v);
    check_val({4'h0, rd_v}, 12'h05c);
    i_host.rd(8'h09, rd_v);
    check_val({4'h0, rd_v}, 12'h000);
    // analog dc after the first 4096-step period; the 10 kHz rate drops two code bits
    cyc(49180);
    @(negedge clk);
    check_val(code, 12'h5c8);
    check_val(lvl, 12'h5c8);
    check_val({6'h0, sink_on}, 12'h03f);
    // mixed at 40 kHz: low nibble 3 is dropped
    @(posedge clk);
    rate <= 3'h4;
    dim_mode <= 1'b1;
    i_host.wr(`LDC_OFS_BRIGHT_HI, 8'h10);
    cyc(12328);
    @(negedge clk);
    check_val(code, 12'h100);
    for (int x = 0; x < 4; x++) begin
      if (x > 0) begin
        xp <= 2'(x);
        cyc(PER + 40);
      end
      measure();
      check_cnt(on0, exp_ontime(2'(x)));
      check_val(lvl_on, exp_lvl(2'(x)));
      if (x == 1) check_phase();
    end
    // a random set of strings: offsets follow the new count
    xp <= 2'h1;
    led_en <= 6'($urandom_range(63, 1));
    cyc(PER + 40);
    measure();
    check_phase();
    // direct mode follows the input one clock late, all strings together
    src <= LDC_SRC_DIRECT;
    cyc(PER + 40);
    fork
      i_host.pulse(25 + int'($urandom % 6000));
      begin
        @(negedge clk);
        exp_on = led_en & {6{pwm}};
        repeat (6399) begin
          @(negedge clk);
          check_val({6'h0, sink_on}, {6'h0, exp_on});
          exp_on = led_en & {6{pwm}};
        end
      end
    join
    // no register interface: floating strap gives mixed at 25 percent from the duty;
    // the only input period seen so far had no high time, so the duty code is zero
    reg_if <= 1'b0;
    cyc(PER + 40);
    @(negedge clk);
    check_val(lvl, exp_lvl(2'h1));
    check_val(code, 12'h000);
    check_val({6'h0, sink_on}, 12'h000);
    finish_test();
  end
endmodule
